/* core/bert_pkg.sv */
// Constants, types and pattern functions shared by the serial bit error rate tester
package bert_pkg;

    localparam int unsigned GEN_WIDTH         = 32;
    localparam int unsigned BIT_COUNT_WIDTH   = 32;
    localparam int unsigned ERROR_COUNT_WIDTH = 24;

    localparam logic [7:0] ADDR_CTRL        = 8'h00;
    localparam logic [7:0] ADDR_LENGTH      = 8'h04;
    localparam logic [7:0] ADDR_PATTERN     = 8'h08;
    localparam logic [7:0] ADDR_STATUS      = 8'h0c;
    localparam logic [7:0] ADDR_BIT_COUNT   = 8'h10;
    localparam logic [7:0] ADDR_ERROR_COUNT = 8'h14;

    localparam int unsigned CTRL_ENABLE     = 0;
    localparam int unsigned CTRL_QRSS       = 1;
    localparam int unsigned CTRL_REPETITIVE = 2;
    localparam int unsigned CTRL_RESYNC_OFF = 3;
    localparam int unsigned CTRL_LOAD       = 4;
    localparam int unsigned CTRL_INSERT     = 5;
    localparam int unsigned CTRL_UPDATE     = 6;
    localparam int unsigned CTRL_INVERT     = 7;

    localparam int unsigned LEN_LSB = 0;
    localparam int unsigned TAP_LSB = 8;

    localparam int unsigned STAT_LOCK_LOST   = 0;
    localparam int unsigned STAT_UPDATE_DONE = 1;
    localparam int unsigned STAT_BITS_ZERO   = 2;
    localparam int unsigned STAT_ERRS_ZERO   = 3;

    localparam logic [4:0]  LEN_RESET     = 5'h08;
    localparam logic [4:0]  TAP_RESET     = 5'h04;
    localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
    localparam logic [31:0] SEED_ONES     = 32'hffff_ffff;

    localparam logic [5:0] SYNC_LAST        = 6'h1f;
    localparam logic [5:0] WINDOW_LAST      = 6'h3f;
    localparam logic [2:0] RESYNC_THRESHOLD = 3'h6;

    localparam int unsigned QRSS_TAP_A    = 16;
    localparam int unsigned QRSS_TAP_B    = 19;
    localparam int unsigned QRSS_ZERO_RUN = 14;
    localparam int unsigned LOCKUP_BITS   = 31;

    localparam int unsigned PIN_TX_CLOCK = 0;
    localparam int unsigned PIN_RX_CLOCK = 1;
    localparam int unsigned PIN_RX_DATA  = 2;
    localparam int unsigned PIN_RX_GATE  = 3;
    localparam int unsigned PIN_TX_GATE  = 4;
    localparam int unsigned PIN_COUNT    = 5;

    typedef enum logic [1:0] {
        RX_LOAD   = 2'b00,
        RX_VERIFY = 2'b01,
        RX_LOCK   = 2'b10
    } rx_state_t;

    typedef struct packed {
        logic        enable;
        logic        qrss;
        logic        repetitive;
        logic        resync_off;
        logic        invert;
        logic [4:0]  len_m1;
        logic [4:0]  tap_m1;
        logic [31:0] pattern;
    } cfg_t;

    // Feedback into bit 1 of the generator
    function automatic logic gen_feedback(input logic [31:0] r, input cfg_t c);
        logic fb;
        fb = 1'b0;
        if (c.repetitive) begin
            fb = r[c.len_m1];
        end else begin
            fb = c.qrss ? (r[QRSS_TAP_A] ^ r[QRSS_TAP_B]) : (r[c.len_m1] ^ r[c.tap_m1]);
            if (r[LOCKUP_BITS-1:0] == '0) begin
                fb = 1'b1;
            end
        end
        return fb;
    endfunction

    // Bit offered for transmission or comparison
    function automatic logic gen_output(input logic [31:0] r, input cfg_t c);
        logic ob;
        ob = gen_feedback(r, c);
        if (c.qrss && !c.repetitive && (r[QRSS_ZERO_RUN-1:0] == '0)) begin
            ob = 1'b1;
        end
        return ob;
    endfunction

endpackage

/* core/sat_counter.sv */
// Saturating event counter with clear that never loses a coincident event
`timescale 1ns/1ps
module sat_counter #(
    parameter int unsigned WIDTH = 32
) (
    input  wire logic             clock_in,
    input  wire logic             rst_b_in,
    input  wire logic             clear_in,
    input  wire logic             inc_in,
    output logic [WIDTH-1:0]      count_out
);
    localparam logic [WIDTH-1:0] COUNT_MAX = '1;
    localparam logic [WIDTH-1:0] COUNT_ONE = WIDTH'(1);

    wire logic [WIDTH-1:0] next_count;

    assign next_count = clear_in ? (inc_in ? COUNT_ONE : '0) :
                        (inc_in && count_out != COUNT_MAX) ? count_out + COUNT_ONE :
                        count_out;

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            count_out <= '0;
        end else begin
            count_out <= next_count;
        end
    end
endmodule

/* core/pattern_gen.sv */
// Transmit pattern generator: PRBS, QRSS or repetitive pattern
`timescale 1ns/1ps
module pattern_gen
    import bert_pkg::*;
(
    input  wire logic          clock_in,
    input  wire logic          rst_b_in,
    input  bert_pkg::cfg_t     cfg_in,
    input  wire logic          load_in,
    input  wire logic          advance_in,
    output logic               bit_out
);
    logic [31:0] shift;

    wire logic [31:0] next_seed;

    assign next_seed = cfg_in.repetitive ? cfg_in.pattern : SEED_ONES;

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            shift   <= SEED_ONES;
            bit_out <= 1'b0;
        end else if (load_in) begin
            shift <= next_seed;
        end else if (advance_in) begin
            bit_out <= gen_output(shift, cfg_in);
            shift   <= {shift[30:0], gen_feedback(shift, cfg_in)};
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    AST_TX_SEED: assert property (load_in && !cfg_in.repetitive |=> shift == SEED_ONES)
        else $error("Transmit generator not seeded with ones");
    AST_TX_PRELOAD: assert property (load_in && cfg_in.repetitive |=>
                                     shift == $past(cfg_in.pattern))
        else $error("Transmit generator not preloaded with pattern");
endmodule

/* core/serial_bert.sv */
// Serial bit error rate tester with APB register access
//
// Function
// - Data gates skip gapped bit positions both ways
// - x86 mode: keep sending when gate pin is output
// - Halt normal traffic while tester runs
// - Tester overrides link; disabling restores it
// - Send pattern payload, check received payload
// - PRBS 2^9, 2^15, 2^23 minus one, QRSS
// - Repetitive pattern, length 1 to 32
// - 24-bit error and 32-bit bit counters
// - Single bit errors inserted on request
// - Checker syncs local generator to payload
// - 32-bit generator shifts toward bit 32
// - Feedback taps n xor y, or n
// - Compared value is generator feedback bit
// - QRSS taps 17, 20; force one
// - PRBS and QRSS: force feedback one when bits 1-31 zero
// - Sync method follows programmed pattern type
// - PRBS: load 32, verify 32, lock
// - PRBS lock: threshold misses start resync
// - Repetitive: search pattern, verify 32, lock
// - Repetitive lock: threshold misses start resync
// - Lock lost flag outside locked state
// - Count compared bits and errors when locked
// - Saturate; update copies, clears, then done
// - Seed ones, or preload repetitive pattern
`timescale 1ns/1ps
module serial_bert
    import bert_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        tx_clock_in,
    input  wire logic        rx_clock_in,
    input  wire logic        rx_data_in,
    input  wire logic        receive_data_gate_in,
    input  wire logic        transmit_data_gate_in,
    input  wire logic        x86_mode_in,
    input  wire logic        transmit_gate_is_output_in,
    input  wire logic        normal_tx_data_in,
    output logic             tx_data_out,
    output logic             normal_traffic_halt_out,
    output logic             pattern_lock_lost_out,
    output logic             counter_update_done_out
);
    cfg_t                         cfg;
    logic [PIN_COUNT-1:0]         sync_a;
    logic [PIN_COUNT-1:0]         sync_b;
    logic                         tx_clock_prev;
    logic                         rx_clock_prev;
    logic                         start_pulse;
    logic                         insert_pending;
    logic                         error_flip;
    logic                         update_strobe;
    logic                         update_strobe_prev;
    logic                         update_copy;
    logic                         zero_force;
    logic [31:0]                  rx_gen;
    rx_state_t                    rx_state;
    logic [5:0]                   phase;
    logic [2:0]                   misses;
    logic [BIT_COUNT_WIDTH-1:0]   bit_reg;
    logic [ERROR_COUNT_WIDTH-1:0] err_reg;

    wire logic                         wr_en;
    wire logic                         wr_ctrl;
    wire logic                         addr_known;
    wire logic [31:0]                  next_prdata;
    wire logic                         tx_fall;
    wire logic                         rx_rise;
    wire logic                         tx_gate_ok;
    wire logic                         tx_advance;
    wire logic                         rx_advance;
    wire logic                         rx_bit;
    wire logic                         gen_bit;
    wire logic                         rx_fb;
    wire logic                         rx_expect;
    wire logic                         rx_match;
    wire logic [31:0]                  rx_shift_in;
    wire logic [31:0]                  rx_shift_fb;
    wire logic [31:0]                  len_mask;
    wire logic                         rep_found;
    wire logic                         resync_hit;
    wire logic                         count_bit;
    wire logic                         count_err;
    wire logic [BIT_COUNT_WIDTH-1:0]   bit_count;
    wire logic [ERROR_COUNT_WIDTH-1:0] err_count;
    rx_state_t                         next_rx_state;
    wire logic [5:0]                   next_phase;
    wire logic [2:0]                   next_misses;
    wire logic [31:0]                  next_rx_gen;
    wire logic                         next_tx_data;

    // Register bus decode; zero wait states
    assign wr_en      = psel_in && penable_in && pwrite_in;
    assign wr_ctrl    = wr_en && (paddr_in == ADDR_CTRL);
    assign addr_known = (paddr_in == ADDR_CTRL) || (paddr_in == ADDR_LENGTH) ||
                        (paddr_in == ADDR_PATTERN) || (paddr_in == ADDR_STATUS) ||
                        (paddr_in == ADDR_BIT_COUNT) || (paddr_in == ADDR_ERROR_COUNT);
    assign pready_out = 1'b1;

    assign next_prdata =
        (paddr_in == ADDR_CTRL)    ? 32'({cfg.invert, update_strobe, 2'b00, cfg.resync_off,
                                          cfg.repetitive, cfg.qrss, cfg.enable}) :
        (paddr_in == ADDR_LENGTH)  ? 32'({cfg.tap_m1, 3'b000, cfg.len_m1}) :
        (paddr_in == ADDR_PATTERN) ? cfg.pattern :
        (paddr_in == ADDR_STATUS)  ? 32'({(err_reg == '0) && !zero_force,
                                          (bit_reg == '0) && !zero_force,
                                          counter_update_done_out, pattern_lock_lost_out}) :
        (paddr_in == ADDR_BIT_COUNT)   ? bit_reg :
        (paddr_in == ADDR_ERROR_COUNT) ? 32'(err_reg) : 32'h0000_0000;

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else if (psel_in && !penable_in) begin
            prdata_out  <= next_prdata;
            pslverr_out <= !addr_known;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            cfg <= '{enable: 1'b0, qrss: 1'b0, repetitive: 1'b0, resync_off: 1'b0,
                     invert: 1'b0, len_m1: LEN_RESET, tap_m1: TAP_RESET,
                     pattern: PATTERN_RESET};
            update_strobe <= 1'b0;
        end else if (wr_ctrl) begin
            cfg.enable     <= pwdata_in[CTRL_ENABLE];
            cfg.qrss       <= pwdata_in[CTRL_QRSS];
            cfg.repetitive <= pwdata_in[CTRL_REPETITIVE];
            cfg.resync_off <= pwdata_in[CTRL_RESYNC_OFF];
            cfg.invert     <= pwdata_in[CTRL_INVERT];
            update_strobe  <= pwdata_in[CTRL_UPDATE];
        end else if (wr_en && paddr_in == ADDR_LENGTH) begin
            cfg.len_m1 <= pwdata_in[LEN_LSB +: 5];
            cfg.tap_m1 <= pwdata_in[TAP_LSB +: 5];
        end else if (wr_en && paddr_in == ADDR_PATTERN) begin
            cfg.pattern <= pwdata_in;
        end
    end

    // New pattern on explicit load or on enabling
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= wr_ctrl && (pwdata_in[CTRL_LOAD] ||
                                       (pwdata_in[CTRL_ENABLE] && !cfg.enable));
        end
    end

    // Pins from the line side: two stages, then edge detection
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            sync_a        <= '0;
            sync_b        <= '0;
            tx_clock_prev <= 1'b0;
            rx_clock_prev <= 1'b0;
        end else begin
            sync_a        <= {transmit_data_gate_in, receive_data_gate_in, rx_data_in,
                              rx_clock_in, tx_clock_in};
            sync_b        <= sync_a;
            tx_clock_prev <= sync_b[PIN_TX_CLOCK];
            rx_clock_prev <= sync_b[PIN_RX_CLOCK];
        end
    end

    assign tx_fall    = tx_clock_prev && !sync_b[PIN_TX_CLOCK];
    assign rx_rise    = !rx_clock_prev && sync_b[PIN_RX_CLOCK];
    assign rx_bit     = sync_b[PIN_RX_DATA];
    assign tx_gate_ok = sync_b[PIN_TX_GATE] || (x86_mode_in && transmit_gate_is_output_in);
    assign tx_advance = cfg.enable && tx_fall && tx_gate_ok;
    assign rx_advance = cfg.enable && rx_rise && sync_b[PIN_RX_GATE];

    // Transmit side
    pattern_gen u_tx_gen (
        .clock_in   (clock_in),
        .rst_b_in   (rst_b_in),
        .cfg_in     (cfg),
        .load_in    (start_pulse),
        .advance_in (tx_advance),
        .bit_out    (gen_bit)
    );

    // Single error: pending until the next payload bit, a new request wins over the clear
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            insert_pending <= 1'b0;
            error_flip     <= 1'b0;
        end else begin
            insert_pending <= (wr_ctrl && pwdata_in[CTRL_INSERT]) ||
                              (insert_pending && !tx_advance);
            if (tx_advance) begin
                error_flip <= insert_pending;
            end
        end
    end

    assign next_tx_data = cfg.enable ? (gen_bit ^ error_flip ^ cfg.invert) :
                          normal_tx_data_in;
    assign normal_traffic_halt_out = cfg.enable;

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            tx_data_out <= 1'b0;
        end else begin
            tx_data_out <= next_tx_data;
        end
    end

    // Receive checker
    assign rx_fb       = gen_feedback(rx_gen, cfg);
    assign rx_expect   = gen_output(rx_gen, cfg);
    assign rx_match    = (rx_expect == rx_bit);
    assign rx_shift_in = {rx_gen[30:0], rx_bit};
    assign rx_shift_fb = {rx_gen[30:0], rx_fb};
    assign len_mask    = SEED_ONES >> (5'h1f - cfg.len_m1);
    assign rep_found   = (rx_shift_in & len_mask) == (cfg.pattern & len_mask);
    assign resync_hit  = !rx_match && (misses == RESYNC_THRESHOLD - 3'h1) &&
                         !cfg.resync_off;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            RX_LOAD: begin
                if (cfg.repetitive ? rep_found : (phase == SYNC_LAST)) begin
                    next_rx_state = RX_VERIFY;
                end
            end
            RX_VERIFY: begin
                if (!rx_match) begin
                    next_rx_state = RX_LOAD;
                end else if (phase == SYNC_LAST) begin
                    next_rx_state = RX_LOCK;
                end
            end
            RX_LOCK: begin
                if (resync_hit) begin
                    next_rx_state = RX_LOAD;
                end
            end
            default: begin
                next_rx_state = RX_LOAD;
            end
        endcase
    end

    assign next_rx_gen = (rx_state == RX_LOAD) ? rx_shift_in : rx_shift_fb;
    assign next_phase  = (next_rx_state != rx_state) ? 6'h00 : phase + 6'h01;
    assign next_misses = (next_rx_state != RX_LOCK || phase == WINDOW_LAST) ? 3'h0 :
                         misses + {2'b00, !rx_match};

    always_ff @(posedge clock_in) begin
        if (!rst_b_in || start_pulse || !cfg.enable) begin
            rx_state <= RX_LOAD;
            rx_gen   <= '0;
            phase    <= 6'h00;
            misses   <= 3'h0;
        end else if (rx_advance) begin
            rx_state <= next_rx_state;
            rx_gen   <= next_rx_gen;
            phase    <= next_phase;
            misses   <= next_misses;
        end
    end

    assign pattern_lock_lost_out = (rx_state != RX_LOCK);
    assign count_bit = rx_advance && (rx_state == RX_LOCK);
    assign count_err = count_bit && !rx_match;

    // Counters and the update sequence
    sat_counter #(.WIDTH(BIT_COUNT_WIDTH)) u_bit_counter (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .clear_in  (update_copy),
        .inc_in    (count_bit),
        .count_out (bit_count)
    );

    sat_counter #(.WIDTH(ERROR_COUNT_WIDTH)) u_err_counter (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .clear_in  (update_copy),
        .inc_in    (count_err),
        .count_out (err_count)
    );

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            update_strobe_prev      <= 1'b0;
            update_copy             <= 1'b0;
            zero_force              <= 1'b0;
            counter_update_done_out <= 1'b0;
            bit_reg                 <= '0;
            err_reg                 <= '0;
        end else begin
            update_strobe_prev <= update_strobe;
            update_copy        <= update_strobe && !update_strobe_prev;
            zero_force         <= update_copy;
            if (update_strobe && !update_strobe_prev) begin
                counter_update_done_out <= 1'b0;
            end else if (zero_force) begin
                counter_update_done_out <= 1'b1;
            end
            if (update_copy) begin
                bit_reg <= bit_count;
                err_reg <= err_count;
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    AST_TX_OVERRIDE: assert property (cfg.enable && $past(cfg.enable) |=>
                                      tx_data_out == $past(gen_bit ^ error_flip ^ cfg.invert))
        else $error("Tester bit not on transmit line");
    AST_TX_RESTORE: assert property (!cfg.enable |=> tx_data_out == $past(normal_tx_data_in))
        else $error("Normal transmit data not restored");
    AST_RX_GAP: assert property (rx_rise && !sync_b[PIN_RX_GATE] && !start_pulse && cfg.enable
                                 |=> $stable(rx_gen) && $stable(phase))
        else $error("Gapped receive bit was processed");
    AST_PRBS_LOCK: assert property (rx_state == RX_VERIFY && rx_advance && rx_match &&
                                    phase == SYNC_LAST && !start_pulse && cfg.enable
                                    |=> !pattern_lock_lost_out)
        else $error("No lock after 32 verified bits");
    AST_LOAD_LEN: assert property (rx_state == RX_LOAD && !cfg.repetitive && rx_advance &&
                                   phase < SYNC_LAST && !start_pulse && cfg.enable
                                   |=> rx_state == RX_LOAD)
        else $error("Left load before 32 bits");
    AST_RESYNC: assert property (rx_state == RX_LOCK && rx_advance && resync_hit &&
                                 !start_pulse && cfg.enable |=> pattern_lock_lost_out)
        else $error("Resync not started at threshold");
    AST_NO_COUNT_LOST: assert property (pattern_lock_lost_out && !update_copy |=>
                                        $stable(bit_count) && $stable(err_count))
        else $error("Counter advanced without lock");
    AST_LOCKUP: assert property (!cfg.repetitive && rx_gen[30:0] == '0 |-> rx_fb)
        else $error("Lock-up state fed back zero");
    AST_UPDATE_SEQ: assert property ($rose(update_strobe) |=> !counter_update_done_out ##1
                                     zero_force && !counter_update_done_out ##1
                                     counter_update_done_out)
        else $error("Counter update sequence wrong");
    AST_INSERT: assert property (tx_advance && insert_pending && cfg.enable |=>
                                 error_flip ##1 tx_data_out != (gen_bit ^ cfg.invert))
        else $error("Requested error not inserted");

    COV_LOCK: cover property (rx_state == RX_VERIFY ##1 rx_state == RX_LOCK);
    COV_RESYNC: cover property (rx_state == RX_LOCK ##1 rx_state == RX_LOAD);
    COV_UPDATE: cover property ($rose(counter_update_done_out));
    COV_ERROR_COUNTED: cover property (count_err);
endmodule

/* verif/line_model.sv */
// Serial line equipment: link clock, payload gate and loopback of sent bits
`timescale 1ns/1ps
module line_model (
    input  wire logic run_in,
    input  wire logic tx_data_in,
    output logic      link_clock_out,
    output logic      tx_gate_out,
    output logic      rx_gate_out,
    output logic      rx_data_out
);
    logic       held    = 1'b0;
    logic       tx_gate = 1'b1;
    logic       rx_gate = 1'b1;
    logic [2:0] slot    = 3'h0;
    // Clock stands high while idle
    initial begin
        link_clock_out = 1'b1;
        forever #400 if (run_in) link_clock_out = ~link_clock_out;
    end
    // Held from fall to fall, so settled at the rising sample edge
    // Every eighth slot gapped; receive gate trails by the loopback bit
    always @(negedge link_clock_out) begin
        held    = tx_data_in;
        rx_gate = tx_gate;
        slot    = slot + 3'h1;
        tx_gate = (slot != 3'h7);
    end
    assign tx_gate_out = run_in && tx_gate;
    assign rx_gate_out = run_in && rx_gate;
    assign rx_data_out = run_in ? held : ~held;
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the serial bit error rate tester
`timescale 1ns/1ps
module tb_top;
    import bert_pkg::*;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0, ntx = 1'b0, x86 = 1'b0;
    logic        pready, perr, lclk, tgate, rgate, rxd, txd, halt, lost, done;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          fail_count = 0, total_checks = 0, cycles = 0;

    always #50 clock_in = ~clock_in;

    serial_bert i_dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
        .tx_clock_in(lclk), .rx_clock_in(lclk), .rx_data_in(rxd),
        .receive_data_gate_in(rgate), .transmit_data_gate_in(tgate), .x86_mode_in(x86),
        .transmit_gate_is_output_in(x86), .normal_tx_data_in(ntx), .tx_data_out(txd),
        .normal_traffic_halt_out(halt), .pattern_lock_lost_out(lost),
        .counter_update_done_out(done));
    line_model i_line (.run_in(run), .tx_data_in(txd), .link_clock_out(lclk),
        .tx_gate_out(tgate), .rx_gate_out(rgate), .rx_data_out(rxd));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock_in);
        penable <= 1'b1;
        do @(posedge clock_in); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask

    task automatic t_reset;
        apb(0, ADDR_STATUS, 0);
        chk("status", 32'h0000_000d, rd);
        apb(0, ADDR_LENGTH, 0);
        chk("length", 32'h0000_0408, rd);
        apb(0, 8'h40, 0);
        chk("slverr", 1, perr);
        chk("halt", 0, halt);
        $display("reset test done");
    endtask

    task automatic t_prbs;
        apb(1, ADDR_LENGTH, 32'h0000_0408);
        apb(1, ADDR_CTRL, 32'h0000_0001);
        @(posedge clock_in);
        chk("halt", 1, halt);
        run <= 1'b1;
        repeat (1600) @(posedge clock_in);
        chk("prbs lock lost", 0, lost);
        apb(1, ADDR_CTRL, 32'h0000_0021);
        repeat (80) @(posedge clock_in);
        apb(1, ADDR_CTRL, 32'h0000_0041);
        repeat (8) @(posedge clock_in);
        chk("update done", 1, done);
        apb(0, ADDR_ERROR_COUNT, 0);
        chk("errors", 1, rd);
        chk("lock kept", 0, lost);
        apb(1, ADDR_CTRL, 32'h0000_0089);
        repeat (200) @(posedge clock_in);
        chk("resync off", 0, lost);
        apb(1, ADDR_CTRL, 32'h0000_0081);
        repeat (200) @(posedge clock_in);
        chk("resync", 1, lost);
        $display("prbs test done");
    endtask

    task automatic t_qrss;
        apb(1, ADDR_CTRL, 32'h0000_0013);
        repeat (1600) @(posedge clock_in);
        chk("qrss lock lost", 0, lost);
        $display("qrss test done");
    endtask

    task automatic t_x86;
        int   same = 0;
        logic prev;
        x86 <= 1'b1;
        apb(1, ADDR_LENGTH, 32'h0000_0001);
        apb(1, ADDR_PATTERN, 32'h0000_0001);
        apb(1, ADDR_CTRL, 32'h0000_0015);
        repeat (3) @(negedge lclk);
        prev = txd;
        repeat (16) begin
            @(negedge lclk);
            if (txd === prev) same++;
            prev = txd;
        end
        chk("x86 repeats", 0, same);
        $display("gate output test done");
    endtask

    task automatic t_normal;
        apb(1, ADDR_CTRL, 32'h0);
        ntx <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk("normal one", 1, txd);
        chk("unlocked", 1, lost);
        ntx <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk("normal zero", 0, txd);
        $display("normal test done");
    endtask

    task automatic t_repeat;
        apb(1, ADDR_LENGTH, 32'h0000_0003);
        apb(1, ADDR_PATTERN, 32'h0000_0009);
        apb(1, ADDR_CTRL, 32'h0000_0005);
        repeat (1000) @(posedge clock_in);
        chk("repeat lock lost", 0, lost);
        $display("repetitive test done");
    endtask

    initial begin
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_prbs();
        t_normal();
        t_repeat();
        t_qrss();
        t_x86();
        complete_run();
    end
endmodule
